// [logic/wake_filter_consts.svh]
// Functional notes
// - a filtered change on the chosen pin raises a wake request while asleep
// - any enabled per-pin edge interrupt also raises the wake request
// - rising and falling triggers are enabled each on its own
// - the noise filter sits after edge detection, before the wake output
// - pulses shorter than the filter time give no wake and no flag
// - one pin of sixteen is watched at a time
// - config bit 7 written one enables filtered rising edge wake
// - config bit 6 written one enables filtered falling edge wake
// - falling flag sets on a falling wake, clears when falling enable is zero
// - filter field bits 5:4 selects 1, 2, 4 or 8 ms
// - select field bits 3:0 picks port 0 bits then port 1 bits
// - register resets to zero, reads flags in place of the enables
`ifndef WAKE_FILTER_CONSTS_SVH
`define WAKE_FILTER_CONSTS_SVH

`define WK_CFG_INDEX    16'ha02e
`define WK_STAT_INDEX   16'ha02f
`define WK_MASK_INDEX   16'ha030
`define WK_CFG_RESET    8'h00
`define WK_STAT_RESET   2'h0
`define WK_MASK_RESET   2'h0
`define WK_RISE_EN_BIT  7
`define WK_FALL_EN_BIT  6
`define WK_FILT_LSB     4
`define WK_SRC_LSB      0
`define WK_ST_RISE_BIT  0
`define WK_ST_FALL_BIT  1
`define WK_CLK_HZ       100000000
`define WK_BASE_MS      1
`define WK_MS_CYCLES    ((`WK_CLK_HZ / 1000) * `WK_BASE_MS)
`define WK_RESP_OKAY    2'h0
`define WK_RESP_SLVERR  2'h2

`endif

// [logic/wake_filter_pkg.sv]
package wake_filter_pkg;

    typedef struct packed {
        logic       rise_wake_enable;
        logic       fall_wake_enable;
        logic [1:0] filter_time_select;
        logic [3:0] wake_pin_select;
    } cfg_type;

    typedef enum logic {
        FILT_IDLE  = 1'b0,
        FILT_COUNT = 1'b1
    } filt_state_type;

endpackage

// [logic/gpio_filtered_wakeup.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wake_filter_consts.svh"

module gpio_filtered_wakeup #(
    parameter int ADDR_W    = 20,
    parameter int CNT_W     = 24,
    parameter int MS_CYCLES = `WK_MS_CYCLES
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [7:0]        port0_in,
    input  wire logic [7:0]        port1_in,
    input  wire logic [15:0]       edge_irq_req,
    output var  logic              wake_req,
    output var  logic              irq
);

    // register map, byte address is four times the index
    wire [ADDR_W-1:0] cfg_addr  = ADDR_W'({`WK_CFG_INDEX, 2'b00});
    wire [ADDR_W-1:0] stat_addr = ADDR_W'({`WK_STAT_INDEX, 2'b00});
    wire [ADDR_W-1:0] mask_addr = ADDR_W'({`WK_MASK_INDEX, 2'b00});

    // ---------------- write channel ----------------
    logic              aw_full_q, aw_full_d;
    logic              w_full_q, w_full_d;
    logic [ADDR_W-1:0] waddr_q;
    logic [7:0]        wbyte_q;
    logic              wlane_q;
    logic              bvalid_d;
    logic              awready_d, wready_d;

    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
    wire b_done   = s_axi_bvalid & s_axi_bready;
    wire wr_cfg   = do_write & wlane_q & (waddr_q == cfg_addr);
    wire wr_stat  = do_write & wlane_q & (waddr_q == stat_addr);
    wire wr_mask  = do_write & wlane_q & (waddr_q == mask_addr);
    wire wr_hit   = (waddr_q == cfg_addr) | (waddr_q == stat_addr) | (waddr_q == mask_addr);

    assign aw_full_d = do_write ? 1'b0 : (aw_full_q | aw_take);
    assign w_full_d  = do_write ? 1'b0 : (w_full_q | w_take);
    assign bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);
    assign awready_d = ~aw_full_d & ~bvalid_d;
    assign wready_d  = ~w_full_d & ~bvalid_d;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `WK_RESP_OKAY;
        end else begin
            aw_full_q     <= aw_full_d;
            w_full_q      <= w_full_d;
            s_axi_awready <= awready_d;
            s_axi_wready  <= wready_d;
            s_axi_bvalid  <= bvalid_d;
            if (do_write) begin
                s_axi_bresp <= wr_hit ? `WK_RESP_OKAY : `WK_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waddr_q <= '0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
        end else begin
            if (aw_take) begin
                waddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wbyte_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
            end
        end
    end

    // ---------------- configuration ----------------
    wake_filter_pkg::cfg_type cfg_q, cfg_d;
    wire wake_filter_pkg::cfg_type cfg_wr = wake_filter_pkg::cfg_type'(wbyte_q);

    assign cfg_d = wr_cfg ? cfg_wr : cfg_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= wake_filter_pkg::cfg_type'(`WK_CFG_RESET);
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ---------------- pin selection and filter ----------------
    // one of sixteen pins
    wire [15:0] pins_all = {port1_in, port0_in};
    wire        sel_in   = pins_all[cfg_q.wake_pin_select];
    wire        sel_move = wr_cfg & (cfg_wr.wake_pin_select != cfg_q.wake_pin_select);

    // filter length doubles per code step
    wire [CNT_W-1:0] filt_limit = CNT_W'(MS_CYCLES) << cfg_q.filter_time_select;

    wake_filter_pkg::filt_state_type filt_state_q, filt_state_d;
    logic [CNT_W-1:0] filt_cnt_q, filt_cnt_d;
    logic             level_q, level_d;

    wire differs     = sel_in != level_q;
    wire filt_accept = (filt_state_q == wake_filter_pkg::FILT_COUNT) & differs
                       & (filt_cnt_q >= filt_limit - CNT_W'(1));
    // edges leave the filter only after the full time
    wire acc_rise    = filt_accept & sel_in;
    wire acc_fall    = filt_accept & ~sel_in;

    // restart on any change before time elapses
    always_comb begin
        filt_state_d = filt_state_q;
        filt_cnt_d   = filt_cnt_q;
        level_d      = level_q;
        unique case (filt_state_q)
            wake_filter_pkg::FILT_IDLE: begin
                filt_cnt_d = '0;
                if (differs) begin
                    filt_state_d = wake_filter_pkg::FILT_COUNT;
                end
            end
            wake_filter_pkg::FILT_COUNT: begin
                if (!differs) begin
                    filt_state_d = wake_filter_pkg::FILT_IDLE;
                    filt_cnt_d   = '0;
                end else if (filt_accept) begin
                    filt_state_d = wake_filter_pkg::FILT_IDLE;
                    filt_cnt_d   = '0;
                    level_d      = sel_in;
                end else begin
                    filt_cnt_d = filt_cnt_q + CNT_W'(1);
                end
            end
        endcase
        if (sel_move) begin
            filt_state_d = wake_filter_pkg::FILT_IDLE;
            filt_cnt_d   = '0;
            level_d      = pins_all[cfg_wr.wake_pin_select];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_state_q <= wake_filter_pkg::FILT_IDLE;
            filt_cnt_q   <= '0;
            level_q      <= 1'b0;
        end else begin
            filt_state_q <= filt_state_d;
            filt_cnt_q   <= filt_cnt_d;
            level_q      <= level_d;
        end
    end

    // ---------------- wake flags ----------------
    logic rise_flag_q, fall_flag_q;

    // each edge gated by its own enable
    wire rise_set = acc_rise & cfg_q.rise_wake_enable;
    wire fall_set = acc_fall & cfg_q.fall_wake_enable;

    wire rise_flag_d = rise_set | (rise_flag_q & cfg_d.rise_wake_enable);
    wire fall_flag_d = fall_set | (fall_flag_q & cfg_d.fall_wake_enable);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
        end else begin
            rise_flag_q <= rise_flag_d;
            fall_flag_q <= fall_flag_d;
        end
    end

    // ---------------- interrupt status and mask ----------------
    logic [1:0] stat_q, mask_q;
    wire  [1:0] stat_set = {fall_set, rise_set};
    wire  [1:0] stat_clr = wr_stat ? wbyte_q[1:0] : 2'h0;
    wire  [1:0] stat_d   = (stat_q & ~stat_clr) | stat_set;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= `WK_STAT_RESET;
            mask_q <= `WK_MASK_RESET;
            irq    <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq    <= |(stat_d & (wr_mask ? wbyte_q[1:0] : mask_q));
            if (wr_mask) begin
                mask_q <= wbyte_q[1:0];
            end
        end
    end

    // wake on filtered flag or any enabled edge interrupt
    wire wake_d = rise_flag_d | fall_flag_d | (|edge_irq_req);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= wake_d;
        end
    end

    // ---------------- read channel ----------------
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
    wire rd_cfg  = s_axi_araddr == cfg_addr;
    wire rd_stat = s_axi_araddr == stat_addr;
    wire rd_mask = s_axi_araddr == mask_addr;
    // flags read in place of the enables
    wire [7:0] cfg_rd = {rise_flag_q, fall_flag_q, cfg_q.filter_time_select, cfg_q.wake_pin_select};
    wire [31:0] rd_word = rd_cfg  ? {24'h000000, cfg_rd} :
                          rd_stat ? {30'h00000000, stat_q} :
                          rd_mask ? {30'h00000000, mask_q} : 32'h00000000;
    wire rd_hit = rd_cfg | rd_stat | rd_mask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `WK_RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `WK_RESP_OKAY : `WK_RESP_SLVERR;
            end
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // own count of cycles a change has persisted
    logic [CNT_W-1:0] run_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || !differs || sel_move || filt_accept) begin
            run_q <= '0;
        end else begin
            run_q <= run_q + CNT_W'(1);
        end
    end

    sequence write_both_held;
        aw_full_q && w_full_q && !s_axi_bvalid;
    endsequence

    sequence resp_offered;
        s_axi_bvalid ##0 (s_axi_bresp == (wr_hit ? `WK_RESP_OKAY : `WK_RESP_SLVERR));
    endsequence

    sequence pulse_seen;
        filt_state_q == wake_filter_pkg::FILT_COUNT && !differs;
    endsequence

    write_resp_a: assert property (write_both_held |=> resp_offered)
        else $error("write response missing or wrong");

    filter_full_a: assert property (filt_accept |-> run_q >= filt_limit)
        else $error("edge left filter early");

    short_pulse_a: assert property (pulse_seen and !sel_move |=> filt_cnt_q == '0 && !rise_flag_q || $past(rise_flag_q))
        else $error("short pulse not dropped");

    // counter advances while the change persists
    count_step_a: assert property (filt_state_q == wake_filter_pkg::FILT_COUNT && differs && !filt_accept && !sel_move
        |=> filt_cnt_q == $past(filt_cnt_q) + CNT_W'(1))
        else $error("filter counter did not advance");

    // rising edge sets flag and status
    rise_flag_a: assert property (acc_rise && cfg_q.rise_wake_enable |=> rise_flag_q && stat_q[0])
        else $error("rising flag not set");

    rise_clear_a: assert property (!cfg_q.rise_wake_enable && !cfg_d.rise_wake_enable |=> !rise_flag_q)
        else $error("rising flag set while disabled");

    fall_clear_a: assert property (!cfg_q.fall_wake_enable && !cfg_d.fall_wake_enable |=> !fall_flag_q)
        else $error("falling flag set while disabled");

    fall_flag_a: assert property (acc_fall && cfg_q.fall_wake_enable |=> fall_flag_q && stat_q[1])
        else $error("falling flag not set");

    edge_wake_a: assert property (|edge_irq_req |=> wake_req)
        else $error("edge interrupt did not wake");

    pin_move_a: assert property (sel_move |=> filt_state_q == wake_filter_pkg::FILT_IDLE && filt_cnt_q == '0)
        else $error("filter not restarted on pin change");

    cfg_read_a: assert property (ar_take && rd_cfg |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(cfg_rd))
        else $error("config read data wrong");

    irq_level_a: assert property (|(stat_q & mask_q) |-> irq)
        else $error("interrupt low with unmasked status");

    irq_quiet_a: assert property (!(|(stat_q & mask_q)) |-> !irq)
        else $error("interrupt high with no unmasked status");

    // a change held for the full time is accepted
    filter_late_a: assert property (differs && run_q >= filt_limit |-> filt_accept)
        else $error("change held too long in filter");

    // a set flag holds the wake request
    wake_flag_a: assert property (rise_flag_q || fall_flag_q |-> wake_req)
        else $error("wake request low with flag set");

endmodule
`default_nettype wire

// [bench/wake_partner.sv]
`timescale 1ns/10ps
`default_nettype none

module wake_partner (
    input  wire logic       aclk,
    input  wire logic       wake_req,
    output var  logic [7:0] port0_in,
    output var  logic [7:0] port1_in
);
    logic [15:0] pins_q     = 16'h0;
    logic        wake_old_q = 1'b0;
    int          wake_count = 0;

    assign {port1_in, port0_in} = pins_q;

    // power manager counts each new wake request
    always @(posedge aclk) begin
        wake_old_q <= wake_req;
        if (wake_req && !wake_old_q) begin
            wake_count <= wake_count + 1;
        end
    end

    task automatic drive(input int idx, input logic lvl);
        @(posedge aclk);
        pins_q[idx] <= lvl;
    endtask

    task automatic pulse(input int idx, input logic lvl, input int len);
        drive(idx, lvl);
        repeat (len) @(posedge aclk);
        pins_q[idx] <= ~lvl;
    endtask
endmodule

`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam logic [19:0] CFG_A  = 20'h280b8;
    localparam logic [19:0] STAT_A = 20'h280bc;
    localparam logic [19:0] MASK_A = 20'h280c0;

    logic        aclk     = 1'b0;
    logic        aresetn  = 1'b0;
    logic [19:0] awaddr   = 20'h0;
    logic [19:0] araddr   = 20'h0;
    logic [31:0] wdata    = 32'h0;
    logic        awvalid  = 1'b0;
    logic        wvalid   = 1'b0;
    logic        bready   = 1'b0;
    logic        arvalid  = 1'b0;
    logic        rready   = 1'b0;
    logic [15:0] edge_irq = 16'h0;
    logic [3:0]  wstrb    = 4'hf;
    wire logic   awready, wready, bvalid, arready, rvalid, wake_req, irq;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0]  port0, port1;
    logic [31:0] rd;
    logic [1:0]  resp;
    logic [7:0]  cfg;
    logic [3:0]  src;
    int          filt;
    int          fail_count  = 0;
    int          check_count = 0;

    always #5 aclk = ~aclk;

    gpio_filtered_wakeup #(.MS_CYCLES(8)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port0_in(port0), .port1_in(port1), .edge_irq_req(edge_irq),
        .wake_req(wake_req), .irq(irq)
    );

    wake_partner u_pins (
        .aclk(aclk), .wake_req(wake_req), .port0_in(port0), .port1_in(port1)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic guard(input int n);
        if (n >= 50) begin
            $display("wrong value at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
            fail_count++;
            results();
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axi_write(input logic [19:0] a, input logic [7:0] d);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        resp = bresp;
        guard(n);
    endtask

    task automatic axi_read(input logic [19:0] a);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        rd   = rdata;
        resp = rresp;
        guard(n);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(CFG_A);
        check(rd, 32'h0);
        axi_read(STAT_A);
        check(rd, 32'h0);
        axi_read(MASK_A);
        check(rd, 32'h0);
        check({30'h0, wake_req, irq}, 32'h0);
        axi_read(20'h280c4);
        check({rd[29:0], resp}, 32'h2);
        axi_write(20'h280c4, 8'hff);
        check({30'h0, resp}, 32'h2);
        $display("test reset done");
        axi_write(MASK_A, 8'h01);
        for (int k = 0; k < 4; k++) begin
            src  = 4'(k * 5);
            filt = 8 << k;
            cfg  = {2'b10, 2'(k), src};
            axi_write(CFG_A, cfg);
            axi_read(CFG_A);
            check(rd, {26'h0, cfg[5:0]});
            u_pins.pulse(int'(src), 1'b1, filt - 2);
            step(filt + 4);
            axi_read(CFG_A);
            check(rd, {26'h0, cfg[5:0]});
            u_pins.drive(int'(src ^ 4'h1), 1'b1);
            step(filt + 4);
            axi_read(CFG_A);
            check(rd, {26'h0, cfg[5:0]});
            u_pins.drive(int'(src ^ 4'h1), 1'b0);
            u_pins.drive(int'(src), 1'b1);
            step(filt + 4);
            axi_read(CFG_A);
            check(rd, {24'h0, cfg});
            check({30'h0, wake_req, irq}, 32'h3);
            axi_read(STAT_A);
            check(rd, 32'h1);
            axi_write(STAT_A, 8'h01);
            step(2);
            check({31'h0, irq}, 32'h0);
            axi_write(CFG_A, {2'b00, cfg[5:0]});
            axi_read(CFG_A);
            check(rd, {26'h0, cfg[5:0]});
            check({31'h0, wake_req}, 32'h0);
            u_pins.drive(int'(src), 1'b0);
            step(filt + 4);
            $display("test rise select %0d done", k);
        end
        axi_write(CFG_A, 8'h5b);
        u_pins.drive(11, 1'b1);
        step(20);
        axi_read(CFG_A);
        check(rd, 32'h1b);
        u_pins.pulse(11, 1'b0, 14);
        step(20);
        axi_read(CFG_A);
        check(rd, 32'h1b);
        u_pins.drive(11, 1'b0);
        step(20);
        axi_read(CFG_A);
        check(rd, 32'h5b);
        axi_read(STAT_A);
        check(rd, 32'h2);
        check({30'h0, wake_req, irq}, 32'h2);
        axi_write(STAT_A, 8'h02);
        axi_write(CFG_A, 8'h00);
        axi_read(CFG_A);
        check(rd, 32'h0);
        check({31'h0, wake_req}, 32'h0);
        $display("test fall wake done");
        @(posedge aclk);
        edge_irq <= 16'h0010;
        step(3);
        check({31'h0, wake_req}, 32'h1);
        edge_irq <= 16'h0000;
        step(3);
        check({31'h0, wake_req}, 32'h0);
        check(32'(u_pins.wake_count), 32'h6);
        $display("test edge wake done");
        axi_write(MASK_A, 8'h03);
        axi_write(CFG_A, 8'hc3);
        u_pins.drive(3, 1'b1);
        step(12);
        axi_read(CFG_A);
        check(rd, 32'h83);
        u_pins.drive(3, 1'b0);
        step(12);
        axi_read(CFG_A);
        check(rd, 32'hc3);
        axi_read(STAT_A);
        check(rd, 32'h3);
        check({30'h0, wake_req, irq}, 32'h3);
        wstrb <= 4'h0;
        axi_write(CFG_A, 8'h00);
        check({30'h0, resp}, 32'h0);
        axi_read(CFG_A);
        check(rd, 32'hc3);
        wstrb <= 4'hf;
        axi_write(STAT_A, 8'h03);
        step(2);
        check({31'h0, irq}, 32'h0);
        axi_write(CFG_A, 8'h00);
        axi_read(CFG_A);
        check(rd, 32'h0);
        check({31'h0, wake_req}, 32'h0);
        check(32'(u_pins.wake_count), 32'h7);
        $display("test both edges done");
        results();
    end
endmodule

`default_nettype wire
